// [hw/lpt_consts.svh]
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH
// clock 125 MHz
`define LPT_CLK_HZ          125000000
// auto-restart retry interval, in ms
`define LPT_RETRY_MS        1000
`define LPT_RETRY_CYC       ((`LPT_CLK_HZ / 1000) * `LPT_RETRY_MS)
// external tone idle time before return to reference, in ns (longest: round down)
`define LPT_TONE_IDLE_NS    42000
`define LPT_TONE_IDLE_CYC   ((`LPT_TONE_IDLE_NS * 125) / 1000)
// internal tone 22 kHz: half period in cycles
`define LPT_TONE_HZ         22000
`define LPT_TONE_HALF_CYC   (`LPT_CLK_HZ / (2 * `LPT_TONE_HZ))
// detector: period window, transmit (tight) and receive (wide), in cycles
`define LPT_DET_TX_MIN      5200
`define LPT_DET_TX_MAX      6200
`define LPT_DET_RX_MIN      4800
`define LPT_DET_RX_MAX      6800
// early-power-fail release delays, ms (encoding arbitrary)
`define LPT_EPF_D0_MS       0
`define LPT_EPF_D1_MS       10
`define LPT_EPF_D2_MS       50
`define LPT_EPF_D3_MS       100
// register indices
`define LPT_ADDR_CTRL       4'h0
`define LPT_ADDR_STAT       4'h1
`define LPT_ADDR_MASK       4'h2
`define LPT_ADDR_EVT        4'h3
// control bit positions
`define LPT_CTL_RESTART     0
`define LPT_CTL_SINKDIS     1
`define LPT_CTL_TONESRC     2
`define LPT_CTL_EPFD0       3
`define LPT_CTL_EPFD1       4
`define LPT_CTL_ENABLE      5
// event bit positions; then the control register reset value
`define LPT_EVT_TSD         0
`define LPT_EVT_EPF         1
`define LPT_EVT_TONE        2
`define LPT_CTRL_RESET      8'h00
`endif

// [hw/lpt_pkg.sv]
package lpt_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lpt_bus_t;

    typedef struct packed {
        logic overTemp;
        logic coolOk;
        logic epfLow;
        logic epfHigh;
        logic toneAmpTx;
        logic toneAmpRx;
    } lpt_cmp_t;

    typedef enum logic [1:0] {
        TS_RUN,
        TS_WAIT,
        TS_LATCH
    } lpt_tsd_state_t;
endpackage : lpt_pkg

// [hw/lpt_control.sv]
// Chosen here: the strobed register port and the register addresses.
`include "lpt_consts.svh"
// How it works
// R1: overheat disables output and boost until cool
// R2: auto mode retries every second until cool
// R3: latched mode keeps output off, no retry
// R4: latched fault pulls irq; read releases; write reenables
// R5: latched read clears flag only when cool
// R6: auto mode: read releases irq, restart clears flag
// R7: sink-disable set limits reverse current below 10mA
// R8: sink enabled 25mA, 60mA while tone active
// R9: sleep low turns outputs off, resets control
// R10: control register resets to all zeros
// R11: internal tone gated by tone pin
// R12: external tone on pin reproduced on output
// R13: external tone idle 42us returns to reference
// R14: detector drives open-drain output and flag
// R15: tone valid within 1.5 periods
// R16: transmit tight window, receive wide window
// R17: power-fail low sets flag and irq
// R18: power-fail flag clears after selected delay
// R19: four release delays are parameters
module lpt_control #(
    parameter int RETRY_CYC = `LPT_RETRY_CYC,
    parameter int EPF_D0_MS = `LPT_EPF_D0_MS,
    parameter int EPF_D1_MS = `LPT_EPF_D1_MS,
    parameter int EPF_D2_MS = `LPT_EPF_D2_MS,
    parameter int EPF_D3_MS = `LPT_EPF_D3_MS,
    parameter int MS_CYC    = `LPT_CLK_HZ / 1000
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // register port
    input  wire lpt_pkg::lpt_bus_t bus,
    output logic [7:0]            rdata,
    // pins
    input  wire logic             sleepN,
    input  wire logic             tone_gate_pin,
    input  wire logic             tone_detect_input,
    input  wire lpt_pkg::lpt_cmp_t cmp,
    // outputs to analog, open-drain detector pin and irq
    output logic                  channel_supply_output,
    output logic                  boostEnable,
    output logic                  toneDrive,
    output logic                  outputAtRef,
    output logic                  sinkHigh,
    output logic                  sinkLimit10,
    output logic                  tone_detect_output_oe,
    output logic                  tone_detect_output_o,
    output logic                  irqN
);
    localparam int TX_MIN = `LPT_DET_TX_MIN;
    localparam int TX_MAX = `LPT_DET_TX_MAX;
    localparam int RX_MIN = `LPT_DET_RX_MIN;
    localparam int RX_MAX = `LPT_DET_RX_MAX;

    // detector windows in clock cycles; transmit is the narrower pair

    // two-flop synchronisers for every asynchronous input; only stage B is read
    logic              sleepA_reg;
    logic              sleepB_reg;
    logic              gateA_reg;
    logic              gateB_reg;
    logic              detA_reg;
    logic              detB_reg;
    lpt_pkg::lpt_cmp_t cmpA_reg;
    lpt_pkg::lpt_cmp_t cmpB_reg;
    always_ff @(posedge mclk) begin
        sleepA_reg <= sleepN;
        sleepB_reg <= sleepA_reg;
    end
    always_ff @(posedge mclk) begin
        gateA_reg <= tone_gate_pin;
        gateB_reg <= gateA_reg;
    end
    always_ff @(posedge mclk) begin
        detA_reg <= tone_detect_input;
        detB_reg <= detA_reg;
    end
    // comparators are slow analog levels, so one cycle of skew per bit is harmless
    always_ff @(posedge mclk) begin
        cmpA_reg <= cmp;
        cmpB_reg <= cmpA_reg;
    end
    wire               sleepS = sleepB_reg;
    wire               gateS  = gateB_reg;
    wire               detInS = detB_reg;
    lpt_pkg::lpt_cmp_t cmpS;
    assign cmpS = cmpB_reg;
    // sleep acts as reset, two cycles late through its synchroniser
    wire rst = reset || !sleepS; // R9

    // release delay in cycles for each select code
    function automatic int delayCyc(input logic [1:0] sel);
        case (sel)
            2'h0: delayCyc = EPF_D0_MS * MS_CYC;
            2'h1: delayCyc = EPF_D1_MS * MS_CYC;
            2'h2: delayCyc = EPF_D2_MS * MS_CYC;
            default: delayCyc = EPF_D3_MS * MS_CYC;
        endcase
    endfunction : delayCyc

    // one decoder for every write and the status read, so strobe and index always agree
    function automatic logic hit(input logic strobe, input logic [3:0] addr,
                                 input logic [3:0] index);
        hit = strobe && addr == index;
    endfunction : hit

    // control and mask registers
    logic [7:0] ctrl_reg;
    logic [2:0] mask_reg;
    wire wrCtrl = hit(bus.wr, bus.addr, `LPT_ADDR_CTRL);
    wire wrMask = hit(bus.wr, bus.addr, `LPT_ADDR_MASK);
    wire wrEvt  = hit(bus.wr, bus.addr, `LPT_ADDR_EVT);
    wire rdStat = hit(bus.rd, bus.addr, `LPT_ADDR_STAT);
    always_ff @(posedge mclk) begin
        if (rst)
            ctrl_reg <= `LPT_CTRL_RESET; // R10
        else if (wrCtrl)
            ctrl_reg <= bus.wdata;
    end
    // mask opens enabled so a fault before setup still raises irq
    always_ff @(posedge mclk) begin
        if (rst)
            mask_reg <= 3'h7;
        else if (wrMask)
            mask_reg <= bus.wdata[2:0];
    end
    wire autoMode = ctrl_reg[`LPT_CTL_RESTART];
    wire toneSrc  = ctrl_reg[`LPT_CTL_TONESRC];
    wire sinkDis  = ctrl_reg[`LPT_CTL_SINKDIS];
    wire chanEn   = ctrl_reg[`LPT_CTL_ENABLE];

    // thermal state machine
    lpt_pkg::lpt_tsd_state_t tsState_reg;
    logic [31:0] retry_reg;
    logic        tsdFlag_reg;
    logic        tsdEvt;
    // one retry tick per interval; the count only runs while waiting to restart
    wire retryTick = retry_reg >= 32'(RETRY_CYC - 1);
    always_ff @(posedge mclk) begin
        if (rst || tsState_reg != lpt_pkg::TS_WAIT || retryTick)
            retry_reg <= 32'h0;
        else
            retry_reg <= retry_reg + 32'h1;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            tsState_reg <= lpt_pkg::TS_RUN;
            tsdFlag_reg <= 1'b0;
            tsdEvt      <= 1'b0;
        end else begin
            tsdEvt <= 1'b0;
            case (tsState_reg)
                lpt_pkg::TS_RUN: begin
                    if (cmpS.overTemp) begin
                        tsState_reg <= autoMode ? lpt_pkg::TS_WAIT : lpt_pkg::TS_LATCH; // R1 R3
                        tsdFlag_reg <= 1'b1;
                        tsdEvt      <= 1'b1;
                    end
                end
                lpt_pkg::TS_WAIT: begin
                    // a retry only takes while below the lower threshold
                    if (retryTick && cmpS.coolOk && !cmpS.overTemp) begin
                        tsState_reg <= lpt_pkg::TS_RUN; // R2
                        tsdFlag_reg <= 1'b0; // R6
                    end
                end
                default: begin
                    // a read while still hot leaves the flag for the next read
                    if (rdStat && cmpS.coolOk)
                        tsdFlag_reg <= 1'b0; // R5
                    // re-enable takes a control write, once cool or once a read has cleared the flag
                    if (wrCtrl && (cmpS.coolOk || !tsdFlag_reg))
                        tsState_reg <= lpt_pkg::TS_RUN; // R4
                end
            endcase
        end
    end
    wire tsdOff = tsState_reg != lpt_pkg::TS_RUN;

    // tone generation
    logic [15:0] half_reg;
    logic        intTone_reg;
    logic [15:0] idle_reg;
    // internal tone restarts in phase each time the gate opens
    always_ff @(posedge mclk) begin
        if (rst || !gateS) begin
            half_reg    <= 16'h0;
            intTone_reg <= 1'b0;
        end else if (half_reg >= 16'(`LPT_TONE_HALF_CYC - 1)) begin
            half_reg    <= 16'h0;
            intTone_reg <= !intTone_reg; // R11
        end else begin
            half_reg <= half_reg + 16'h1;
        end
    end
    // idle count saturates, so a long gap never wraps back to tone
    always_ff @(posedge mclk) begin
        if (rst || gateS)
            idle_reg <= 16'h0;
        else if (idle_reg < 16'(`LPT_TONE_IDLE_CYC))
            idle_reg <= idle_reg + 16'h1;
    end
    wire extIdle = idle_reg >= 16'(`LPT_TONE_IDLE_CYC); // R13
    wire toneOnInt = gateS; // R11
    wire toneOnExt = !extIdle; // R12
    wire toneOn    = toneSrc ? toneOnExt : toneOnInt;

    // tone detector: period measured between rising edges
    logic        detPrev_reg;
    logic [15:0] per_reg;
    logic        tonePresent_reg;
    wire detRise = detInS && !detPrev_reg;
    // amplitude and window both follow the transmit or receive side
    wire ampOk   = gateS ? cmpS.toneAmpTx : cmpS.toneAmpRx; // R16
    wire inWin   = gateS ? (per_reg >= 16'(TX_MIN) && per_reg <= 16'(TX_MAX))
                         : (per_reg >= 16'(RX_MIN) && per_reg <= 16'(RX_MAX)); // R16
    // the count stops one past the widest window, so a first edge after silence never passes
    wire perFull = per_reg > 16'(RX_MAX);
    always_ff @(posedge mclk) begin
        if (rst)
            detPrev_reg <= 1'b0;
        else
            detPrev_reg <= detInS;
    end
    always_ff @(posedge mclk) begin
        if (rst || detRise)
            per_reg <= 16'h0;
        else if (!perFull)
            per_reg <= per_reg + 16'h1;
    end
    // one in-window period after the first edge: valid in under 1.5 periods
    always_ff @(posedge mclk) begin
        if (rst)
            tonePresent_reg <= 1'b0;
        else if (detRise)
            tonePresent_reg <= inWin && ampOk; // R15
        else if (perFull)
            tonePresent_reg <= 1'b0;
    end

    // early power fail
    logic        epfFlag_reg;
    logic [31:0] epfCnt_reg;
    logic        epfEvt;
    logic [31:0] epfDelay;
    // delay select is read live, so a change mid-release takes effect at once
    assign epfDelay = 32'(delayCyc({ctrl_reg[`LPT_CTL_EPFD1],
                                    ctrl_reg[`LPT_CTL_EPFD0]})); // R19
    wire epfDone = epfCnt_reg >= epfDelay;
    always_ff @(posedge mclk) begin
        if (rst || cmpS.epfLow || !epfFlag_reg || !cmpS.epfHigh)
            epfCnt_reg <= 32'h0;
        else if (!epfDone)
            epfCnt_reg <= epfCnt_reg + 32'h1;
    end
    always_ff @(posedge mclk) begin
        if (rst)
            epfFlag_reg <= 1'b0;
        else if (cmpS.epfLow)
            epfFlag_reg <= 1'b1; // R17
        else if (epfFlag_reg && cmpS.epfHigh && epfDone)
            epfFlag_reg <= 1'b0; // R18
    end
    // one pulse per fall, so a held fault is not raised again after a clear
    always_ff @(posedge mclk) begin
        if (rst)
            epfEvt <= 1'b0;
        else
            epfEvt <= cmpS.epfLow && !epfFlag_reg;
    end

    // sticky events, write one to clear, set wins
    logic [2:0] evt_reg;
    logic       toneEvt_reg;
    logic [2:0] evtClr;
    wire  [2:0] evtSet = {tonePresent_reg && !toneEvt_reg, epfEvt, tsdEvt};
    // a status read releases irq for thermal and power-fail, not for tone
    always_comb begin
        evtClr = 3'h0;
        if (wrEvt)
            evtClr = evtClr | bus.wdata[2:0];
        if (rdStat)
            evtClr = evtClr | 3'h3; // R4 R6
    end
    always_ff @(posedge mclk) begin
        if (rst)
            toneEvt_reg <= 1'b0;
        else
            toneEvt_reg <= tonePresent_reg;
    end
    always_ff @(posedge mclk) begin
        if (rst)
            evt_reg <= 3'h0;
        else
            evt_reg <= evtSet | (evt_reg & ~evtClr); // R4 R6
    end

    // read port: the mux is combinational, the data a flop held until the next read
    logic [7:0] readMux;
    always_comb begin
        readMux = 8'h00;
        if (bus.addr == `LPT_ADDR_CTRL)
            readMux = ctrl_reg;
        else if (bus.addr == `LPT_ADDR_STAT)
            readMux = {4'h0, tsdOff, tonePresent_reg, epfFlag_reg, tsdFlag_reg}; // R14
        else if (bus.addr == `LPT_ADDR_MASK)
            readMux = {5'h0, mask_reg};
        else if (bus.addr == `LPT_ADDR_EVT)
            readMux = {5'h0, evt_reg};
    end
    always_ff @(posedge mclk) begin
        if (rst)
            rdata <= 8'h00;
        else if (bus.rd)
            rdata <= readMux;
    end

    // supply and boost follow enable unless thermal is holding them off
    always_ff @(posedge mclk) begin
        if (rst) begin
            channel_supply_output <= 1'b0; // R9
            boostEnable           <= 1'b0;
        end else begin
            channel_supply_output <= chanEn && !tsdOff; // R1
            boostEnable           <= chanEn && !tsdOff; // R1
        end
    end

    // tone stage: reference level whenever no tone is on
    always_ff @(posedge mclk) begin
        if (rst) begin
            toneDrive   <= 1'b0;
            outputAtRef <= 1'b1;
        end else begin
            toneDrive   <= toneSrc ? gateS : intTone_reg; // R11 R12
            outputAtRef <= !toneOn; // R13
        end
    end

    // the limit bit always wins over the high sink
    always_ff @(posedge mclk) begin
        if (rst) begin
            sinkLimit10 <= 1'b0;
            sinkHigh    <= 1'b0;
        end else begin
            sinkLimit10 <= sinkDis; // R7
            sinkHigh    <= !sinkDis && toneOn; // R8
        end
    end

    // open drain: pull low only on the low half of a tone already judged valid
    always_ff @(posedge mclk) begin
        if (rst)
            tone_detect_output_oe <= 1'b0;
        else
            tone_detect_output_oe <= tonePresent_reg && !detInS; // R14
    end
    assign tone_detect_output_o = 1'b0;

    // level irq, active low, from unmasked sticky events
    always_ff @(posedge mclk) begin
        if (rst)
            irqN <= 1'b1;
        else
            irqN <= !(|(evt_reg & mask_reg)); // R17
    end
endmodule : lpt_control

// [bench/lpt_control_assertions.sv]
`include "lpt_consts.svh"
module lpt_control_assertions (
    // clock, reset, register port
    input wire logic              mclk,
    input wire logic              reset,
    input wire lpt_pkg::lpt_bus_t bus,
    input wire logic [7:0]        rdata,
    // pins and comparators
    input wire logic              sleepN,
    input wire logic              tone_gate_pin,
    input wire logic              tone_detect_input,
    input wire lpt_pkg::lpt_cmp_t cmp,
    // outputs
    input wire logic              channel_supply_output,
    input wire logic              boostEnable,
    input wire logic              toneDrive,
    input wire logic              outputAtRef,
    input wire logic              sinkHigh,
    input wire logic              sinkLimit10,
    input wire logic              tone_detect_output_oe,
    input wire logic              tone_detect_output_o,
    input wire logic              irqN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // saturates well past the idle time so it never wraps
    int idleCnt;
    always_ff @(posedge mclk) begin
        if (reset || tone_gate_pin) begin
            idleCnt <= 0;
        end else if (idleCnt < 6000) begin
            idleCnt <= idleCnt + 1;
        end
    end
    property p_rst; $fell(reset) |-> !channel_supply_output && !boostEnable && irqN; endproperty
    property p_rdz; $fell(reset) |-> rdata == 8'h00; endproperty
    property p_hot; cmp.overTemp [*5] |-> !channel_supply_output && !boostEnable; endproperty
    property p_slp; !sleepN [*5] |-> !channel_supply_output && !boostEnable; endproperty
    property p_od; tone_detect_output_oe |-> !tone_detect_output_o; endproperty
    // two sync flops and an output register need slack past the idle time
    property p_idle; idleCnt >= 5260 |-> outputAtRef; endproperty
    property p_sink; sinkLimit10 |-> !sinkHigh; endproperty
    property p_unm; bus.rd && bus.addr > `LPT_ADDR_EVT |=> rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not at rest after reset");
    a_rdz: assert property (p_rdz) else $error("read data not cleared by reset");
    a_hot: assert property (p_hot) else $error("supply on while overheated");
    a_slp: assert property (p_slp) else $error("supply on while asleep");
    a_od: assert property (p_od) else $error("open drain pin driven high");
    a_idle: assert property (p_idle) else $error("output not back at reference");
    a_sink: assert property (p_sink) else $error("high sink while limited");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    c_irq: cover property (!irqN);
    c_det: cover property (tone_detect_output_oe);
    c_sup: cover property ($rose(channel_supply_output));
endmodule : lpt_control_assertions

// [bench/lpt_host_model.sv]
module lpt_host_model (
    // clock
    input wire logic         mclk,
    // register port
    output lpt_pkg::lpt_bus_t bus,
    input wire logic [7:0]   rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus = '0;
    // write sequence: one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge mclk);
        bus <= '0;
    endtask : wr
    // read sequence: data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
        d = rdata;
    endtask : rd
endmodule : lpt_host_model

// [bench/lnb_protect_tone_control_test.sv]
`include "lpt_consts.svh"
module lnb_protect_tone_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic              mclk = 1'h0;
    logic              reset = 1'h1;
    logic              sleepN = 1'h1;
    logic              toneGate = 1'h0;
    logic              tdIn = 1'h0;
    lpt_pkg::lpt_cmp_t cmp = '{coolOk: 1'h1, epfHigh: 1'h1, default: 1'h0};
    lpt_pkg::lpt_bus_t bus;
    logic [7:0]        rdata, d;
    logic              sup, boost, tDrv, atRef, sinkHi, sinkLim, tdOe, tdO, irqN;
    int                n_mismatch = 0;
    int                cmp_count = 0;
    int                oeCnt = 0;
    int                dly[4] = '{`LPT_EPF_D0_MS * MS, `LPT_EPF_D1_MS * MS,
                                  `LPT_EPF_D2_MS * MS, `LPT_EPF_D3_MS * MS};
    always #4 mclk = ~mclk;
    always @(posedge mclk) oeCnt <= oeCnt + int'(tdOe === 1'h1);
    lpt_control #(.RETRY_CYC(100), .MS_CYC(MS)) dut (
        .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .sleepN(sleepN),
        .tone_gate_pin(toneGate), .tone_detect_input(tdIn), .cmp(cmp),
        .channel_supply_output(sup), .boostEnable(boost), .toneDrive(tDrv),
        .outputAtRef(atRef), .sinkHigh(sinkHi), .sinkLimit10(sinkLim),
        .tone_detect_output_oe(tdOe), .tone_detect_output_o(tdO), .irqN(irqN));
    lpt_host_model host (.mclk(mclk), .bus(bus), .rdata(rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] ev, input string w);
        cmp_count++;
        if (seen !== ev) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", w, ev, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        host.rd(a, d);
        check(d & m, e, $sformatf("reg %0h", a));
    endtask : rdc
    task automatic heat(input logic h);
        cmp.overTemp <= h;
        cmp.coolOk <= !h;
        cyc(6);
    endtask : heat
    task automatic fail(input logic f);
        cmp.epfLow <= f;
        cmp.epfHigh <= !f;
        cyc(6);
    endtask : fail
    task automatic tone(input int per, input int halves);
        for (int k = 0; k < halves; k++) begin
            tdIn <= !k[0];
            cyc(per / 2);
        end
    endtask : tone
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // time limit: a run that overruns it ends with a mismatch counted
    initial begin
        #700000;
        n_mismatch++;
        conclude();
    end
    initial begin
        cyc(8);
        reset <= 1'h0;
        cyc(2);
        rdc(`LPT_ADDR_CTRL, 8'hFF, 8'h00);
        rdc(`LPT_ADDR_MASK, 8'hFF, 8'h07);
        rdc(4'hC, 8'hFF, 8'h00);
        host.wr(`LPT_ADDR_CTRL, 8'h25);
        rdc(`LPT_ADDR_CTRL, 8'h3F, 8'h25);
        cyc(10);
        check(8'(sup), 8'h01, "sup");
        sleepN <= 1'h0;
        cyc(6);
        check(8'(sup), 8'h00, "sup");
        sleepN <= 1'h1;
        cyc(4);
        rdc(`LPT_ADDR_CTRL, 8'hFF, 8'h00);
        host.wr(`LPT_ADDR_CTRL, 8'h20);
        cyc(10);
        check(8'(sup), 8'h01, "sup");
        heat(1'h1);
        check(8'({sup, boost, irqN}), 8'h00, "thermal");
        rdc(`LPT_ADDR_STAT, 8'h01, 8'h01);
        cyc(2);
        check(8'(irqN), 8'h01, "irqN");
        rdc(`LPT_ADDR_STAT, 8'h01, 8'h01);
        heat(1'h0);
        cyc(300);
        check(8'(sup), 8'h00, "sup");
        host.rd(`LPT_ADDR_STAT, d);
        rdc(`LPT_ADDR_STAT, 8'h01, 8'h00);
        host.wr(`LPT_ADDR_CTRL, 8'h20);
        cyc(10);
        check(8'(sup), 8'h01, "sup");
        host.wr(`LPT_ADDR_CTRL, 8'h21);
        heat(1'h1);
        cyc(300);
        check(8'(sup), 8'h00, "sup");
        rdc(`LPT_ADDR_STAT, 8'h01, 8'h01);
        cyc(2);
        check(8'(irqN), 8'h01, "irqN");
        heat(1'h0);
        cyc(120);
        check(8'(sup), 8'h01, "sup");
        rdc(`LPT_ADDR_STAT, 8'h01, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host.wr(`LPT_ADDR_CTRL, 8'h20 | 8'(k << 3));
            fail(1'h1);
            check(8'(irqN), 8'h00, "irqN");
            rdc(`LPT_ADDR_STAT, 8'h02, 8'h02);
            fail(1'h0);
            cyc(dly[k] * 8 / 10);
            if (dly[k] > 0) rdc(`LPT_ADDR_STAT, 8'h02, 8'h02);
            cyc(dly[k] * 3 / 10 + 10);
            rdc(`LPT_ADDR_STAT, 8'h02, 8'h00);
        end
        toneGate <= 1'h1;
        cyc(3000);
        check(8'({atRef, sinkHi, sinkLim}), 8'h02, "tone on");
        toneGate <= 1'h0;
        cyc(5300);
        check(8'(atRef), 8'h01, "atRef");
        host.wr(`LPT_ADDR_CTRL, 8'h22);
        cyc(5);
        check(8'({sinkLim, sinkHi}), 8'h02, "sink");
        host.wr(`LPT_ADDR_CTRL, 8'h24);
        for (int k = 1; k < 5; k++) begin
            toneGate <= k[0];
            cyc(10);
            check(8'({tDrv, atRef}), 8'(k[0] * 2), "ext");
            cyc(`LPT_TONE_HALF_CYC - 10);
        end
        cyc(5300);
        check(8'(atRef), 8'h01, "atRef");
        host.wr(`LPT_ADDR_CTRL, 8'h20);
        cmp.toneAmpTx <= 1'h1;
        cmp.toneAmpRx <= 1'h1;
        toneGate <= 1'h1;
        tone(`LPT_DET_RX_MIN / 2 + `LPT_DET_TX_MIN / 2, 6);
        rdc(`LPT_ADDR_STAT, 8'h04, 8'h00);
        check(8'(oeCnt != 0), 8'h00, "oe");
        tdIn <= 1'h0;
        toneGate <= 1'h0;
        cyc(8000);
        tone(`LPT_DET_RX_MIN / 2 + `LPT_DET_TX_MIN / 2, 4);
        rdc(`LPT_ADDR_STAT, 8'h04, 8'h04);
        check(8'(oeCnt != 0), 8'h01, "oe");
        conclude();
    end
endmodule : lnb_protect_tone_control_test
bind lpt_control lpt_control_assertions chk (.mclk(mclk), .reset(reset), .bus(bus),
    .rdata(rdata), .sleepN(sleepN), .tone_gate_pin(tone_gate_pin),
    .tone_detect_input(tone_detect_input), .cmp(cmp),
    .channel_supply_output(channel_supply_output), .boostEnable(boostEnable),
    .toneDrive(toneDrive), .outputAtRef(outputAtRef), .sinkHigh(sinkHigh),
    .sinkLimit10(sinkLimit10), .tone_detect_output_oe(tone_detect_output_oe),
    .tone_detect_output_o(tone_detect_output_o), .irqN(irqN));
